// ### inc/sld_params.svh
// constants of the serial-in latched octal driver: stage count, fifo depth, reset values, timing
// assumes a single 20 MHz system clock; pin inputs are synchronised inside the block
//
// Overview of operation
// [R1] eight shift stages feed eight latches; each latch governs one output driver.
// [R2] on each shift clock rise the serial input enters the first stage; the core drops a rise that finds the bit fifo full and sets overrun.
// [R3] each later rise moves every bit one stage toward the cascade output.
// [R4] host keeps serial input stable before the capturing shift clock rise.
// [R5] while latch-load is high each latch copies its shift stage; the core copies only while the bit fifo is empty.
// [R6] latches follow while latch-load stays high and hold once it falls; the core also holds them while bits wait in the fifo.
// [R7] with latch-load tied high, host keeps blanking high while shifting; the bench's transparent test shifts with latch-load high and blanking low.
// [R8] while blanking is high all eight drivers are forced off.
// [R9] blanking never alters latch or shift register contents.
// [R10] while blanking is low each driver follows its own latch.
// [R11] last shift stage drives the cascade serial output for chaining.
// [R12] a bit reaches cascade output after eight rises; first bit ends nearest it.
// [R13] host finishes all eight shifts before pulsing latch-load.
`ifndef SLD_PARAMS_SVH
`define SLD_PARAMS_SVH

`define SLD_STAGES 8
`define SLD_FIFO_DEPTH 16
`define SLD_BIT_WIDTH 1
`define SLD_SR_RESET 8'h00
`define SLD_LATCH_RESET 8'h00
`define SLD_DRV_OFF 8'h00
`define SLD_CLK_PERIOD_NS 50
// least shift clock high time on the pin, and the cycles it spans
`define SLD_MIN_CLK_PULSE_NS 150
`define SLD_MIN_CLK_PULSE_CYC ((`SLD_MIN_CLK_PULSE_NS + `SLD_CLK_PERIOD_NS - 1) / `SLD_CLK_PERIOD_NS)

`endif

// ### inc/sld_pkg.sv
// types shared by the driver core and its bit fifo
// assumes sld_params.svh is reachable on the include path
`include "sld_params.svh"

package sld_pkg;

    typedef logic [`SLD_STAGES-1:0] sld_vec_t;

    // synchronised host pins
    typedef struct packed {
        logic shift_clk;
        logic ser_in;
        logic load;
        logic blank;
    } sld_pins_s;

    // whole state of the driver core except its bit fifo
    typedef struct packed {
        sld_pins_s sync1;
        sld_pins_s sync2;
        logic shift_clk_prev;
        sld_vec_t sr;
        sld_vec_t latch;
        sld_vec_t drv_on;
        logic in_ready;
        logic overrun;
    } sld_state_s;

endpackage

// ### sim/serial_in_latched_octal_driver_tb.sv
// self-checking bench of the octal driver core with a host pin model
// assumes sld_pkg compiled first; one 20 MHz clock
`timescale 1ns/1ps

module serial_in_latched_octal_driver_tb;
    import sld_pkg::*;
    logic clk, rst_n, shift_hold, smp_req;
    logic shift_clk, ser_in, load, blank, ser_out, in_ready, overrun;
    sld_vec_t drv_on;
    sld_vec_t exp_q[$];
    logic [7:0] a, b, c;
    logic bl;
    int fails = 0;
    int num_checks = 0;
    int cyc = 0;

    sld_host_model u_host (.clk(clk), .shift_clk(shift_clk), .ser_in(ser_in), .load(load), .blank(blank));
    sld_driver u_dut (.clk(clk), .rst_n(rst_n), .shift_clk(shift_clk), .ser_in(ser_in), .load(load),
        .blank(blank), .shift_hold(shift_hold), .drv_on(drv_on), .ser_out(ser_out),
        .in_ready(in_ready), .overrun(overrun));

    // ****************************************
    // clock, timeout, scoreboard
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // hang guard: full run needs about 800 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end

    // oldest note is compared when the driver outputs are sampled
    always @(posedge clk) begin
        if (smp_req === 1'b1) begin
            check(drv_on, exp_q.pop_front());
        end
    end

    task automatic expect_drv(input sld_vec_t v);
        exp_q.push_back(v);
        smp_req = 1'b1;
        @(negedge clk);
        smp_req = 1'b0;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        rst_n = 1'b0;
        shift_hold = 1'b0;
        smp_req = 1'b0;
        void'($urandom(55447));
        repeat (4) @(negedge clk);
        check(drv_on, 8'h00);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        check(in_ready, 8'h01);
        check(overrun, 8'h00);
        a = 8'($urandom);
        b = 8'($urandom);
        u_host.shift_byte(a);
        check(ser_out, a[7]);
        u_host.pulse_load();
        u_host.set_blank(1'b0);
        expect_drv(a);
        $display("test load_byte done");
        u_host.set_blank(1'b1);
        expect_drv(8'h00);
        u_host.shift_byte(b);
        u_host.set_blank(1'b0);
        expect_drv(a);
        check(ser_out, b[7]);
        $display("test blank_hold done");
        u_host.set_load(1'b1);
        expect_drv(b);
        u_host.shift_bit(1'b1);
        repeat (8) @(negedge clk);
        expect_drv({b[6:0], 1'b1});
        check(ser_out, b[6]);
        u_host.set_load(1'b0);
        u_host.shift_bit(1'b0);
        repeat (8) @(negedge clk);
        expect_drv({b[6:0], 1'b1});
        $display("test transparent done");
        shift_hold = 1'b1;
        for (int i = 0; i < 17; i++) begin
            u_host.shift_bit(i[0]);
        end
        check(in_ready, 8'h00);
        check(overrun, 8'h01);
        shift_hold = 1'b0;
        repeat (40) @(negedge clk);
        check(in_ready, 8'h01);
        expect_drv({b[6:0], 1'b1});
        $display("test stall done");
        for (int i = 0; i < 4; i++) begin
            bl = 1'($urandom);
            u_host.set_blank(bl);
            expect_drv(bl ? 8'h00 : {b[6:0], 1'b1});
        end
        u_host.set_blank(1'b0);
        $display("test random_blank done");
        // random stalls while shifting; the queue must keep every bit in order
        c = 8'($urandom);
        for (int i = 7; i >= 0; i--) begin
            shift_hold = 1'($urandom);
            u_host.shift_bit(c[i]);
        end
        shift_hold = 1'b0;
        repeat (10) @(negedge clk);
        check(ser_out, c[7]);
        u_host.pulse_load();
        expect_drv(c);
        $display("test random_stall done");
        // reset in mid-run clears the sticky flag and the stored pattern
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        check(overrun, 8'h00);
        check(drv_on, 8'h00);
        check(ser_out, 8'h00);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        check(in_ready, 8'h01);
        u_host.shift_byte(a);
        check(ser_out, a[7]);
        $display("test mid_reset done");
        report_and_stop();
    end
endmodule

// ### sim/sld_host_model.sv
// host controller model: drives shift clock, serial data, latch-load and blanking pins
// assumes a free-running system clock; pins change only at its falling edge
`timescale 1ns/1ps

module sld_host_model (
    input wire logic clk,
    output logic shift_clk,
    output logic ser_in,
    output logic load,
    output logic blank
);
    // ****************************************
    // pin defaults
    // ****************************************
    // blank starts high so partial patterns stay dark
    initial begin
        shift_clk = 1'b0;
        ser_in = 1'b0;
        load = 1'b0;
        blank = 1'b1;
    end

    task automatic wait_lo(input int n);
        repeat (n) @(negedge clk);
    endtask

    // ****************************************
    // pin sequences
    // ****************************************
    // data settles before the rise and holds through the high phase
    task automatic shift_bit(input logic b);
        ser_in = b;
        wait_lo(4);
        shift_clk = 1'b1;
        wait_lo(4);
        shift_clk = 1'b0;
        wait_lo(4);
    endtask

    // msb first, so the first bit ends nearest the cascade output
    task automatic shift_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            shift_bit(v[i]);
        end
    endtask

    // all eight shifts done and drained before the strobe
    task automatic pulse_load();
        wait_lo(8);
        load = 1'b1;
        wait_lo(4);
        load = 1'b0;
        wait_lo(8);
    endtask

    task automatic set_load(input logic b);
        load = b;
        wait_lo(8);
    endtask

    task automatic set_blank(input logic b);
        blank = b;
        wait_lo(6);
    endtask
endmodule

// ### verilog/sld_bit_fifo.sv
// small synchronous fifo carrying captured serial bits to the shift stages
// assumes one clock; writer and reader obey valid/ready
`timescale 1ns/1ps

module sld_bit_fifo #(
    parameter int WIDTH = `SLD_BIT_WIDTH,
    parameter int DEPTH = `SLD_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    import sld_pkg::*;

    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("sld_bit_fifo: depth must be a power of two >= 2");
        end
    end

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } sld_fifo_state_s;

    sld_fifo_state_s st_reg;
    sld_fifo_state_s st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready = (st_reg.count != (AW+1)'(DEPTH));
    assign out_valid = (st_reg.count != '0);
    assign out_data = mem[st_reg.rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
        end
        st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // storage carries no reset; only entries below count are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem[st_reg.wr_ptr] <= in_data;
        end
    end

endmodule

// ### verilog/sld_driver.sv
// serial-in latched octal driver core: pin sync, shift stages, latches, blanking
// assumes host pins are asynchronous to clk and toggle slower than clk
`timescale 1ns/1ps

module sld_driver #(
    parameter int STAGES = `SLD_STAGES,
    parameter int FIFO_DEPTH = `SLD_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic shift_clk,
    input wire logic ser_in,
    input wire logic load,
    input wire logic blank,
    input wire logic shift_hold,
    output sld_pkg::sld_vec_t drv_on,
    output logic ser_out,
    output logic in_ready,
    output logic overrun
);
    import sld_pkg::*;

    initial begin
        if (STAGES != `SLD_STAGES) begin
            $error("sld_driver: stage count is fixed by the package vector");
        end
        if (FIFO_DEPTH < 2) begin
            $error("sld_driver: fifo depth too small");
        end
    end

    // ****************************************************************
    // state
    // ****************************************************************

    sld_state_s st_reg;
    sld_state_s st_next;

    logic clk_rise;
    logic push_valid;
    logic push_ready;
    logic pop_valid;
    logic pop_ready;
    logic pop_bit;
    logic pop;
    logic fifo_idle;
    logic latch_open;

    // ****************************************************************
    // shift clock edge and bit capture
    // ****************************************************************

    // edge taken from the second sync stage only
    assign clk_rise = st_reg.sync2.shift_clk && !st_reg.shift_clk_prev; // [R2]
    // data sampled with the same delay as the clock edge, so host setup carries over
    assign push_valid = clk_rise; // [R4]

    sld_bit_fifo #(
        .WIDTH(`SLD_BIT_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(st_reg.sync2.ser_in),
        .out_valid(pop_valid),
        .out_ready(pop_ready),
        .out_data(pop_bit)
    );

    // a hold from the system stalls shifting; a full fifo then shows on in_ready
    assign pop_ready = !shift_hold;
    assign pop = pop_valid && pop_ready;
    assign fifo_idle = !pop_valid;
    // latches only copy a settled register, so queued bits finish shifting first
    assign latch_open = st_reg.sync2.load && fifo_idle && !pop; // [R5]

    // ****************************************************************
    // next state
    // ****************************************************************

    always_comb begin
        st_next = st_reg;
        st_next.sync1.shift_clk = shift_clk;
        st_next.sync1.ser_in = ser_in;
        st_next.sync1.load = load;
        st_next.sync1.blank = blank;
        st_next.sync2 = st_reg.sync1;
        st_next.shift_clk_prev = st_reg.sync2.shift_clk;
        st_next.in_ready = push_ready;
        // sticky: a rise lost to a full fifo stays visible until reset
        if (push_valid && !push_ready) begin
            st_next.overrun = 1'b1;
        end
        if (pop) begin
            // new bit at stage 0, oldest moves toward the cascade end
            st_next.sr = {st_reg.sr[STAGES-2:0], pop_bit}; // [R2] [R3] [R12]
        end
        if (latch_open) begin
            st_next.latch = st_reg.sr; // [R5] [R6] [R1]
        end
        // blanking gates only the drivers, never the stored bits
        if (st_reg.sync2.blank) begin
            st_next.drv_on = `SLD_DRV_OFF; // [R8] [R9]
        end else begin
            st_next.drv_on = st_reg.latch; // [R10] [R1]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{
                sync1: '0,
                sync2: '0,
                shift_clk_prev: 1'b0,
                sr: `SLD_SR_RESET,
                latch: `SLD_LATCH_RESET,
                drv_on: `SLD_DRV_OFF,
                in_ready: 1'b0,
                overrun: 1'b0
            };
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************

    assign drv_on = st_reg.drv_on;
    assign ser_out = st_reg.sr[STAGES-1]; // [R11]
    assign in_ready = st_reg.in_ready;
    assign overrun = st_reg.overrun;

    // ****************************************************************
    // checks
    // ****************************************************************

    AST_BLANK_OFF: assert property ( // [R8]
        @(posedge clk) disable iff (!rst_n)
        st_reg.sync2.blank |=> (drv_on == `SLD_DRV_OFF))
        else $error("drivers not off while blanked");

    AST_DRV_FOLLOW: assert property ( // [R10]
        @(posedge clk) disable iff (!rst_n)
        !st_reg.sync2.blank |=> (drv_on == $past(st_reg.latch)))
        else $error("drivers do not follow latches");

    AST_SHIFT_IN: assert property ( // [R2]
        @(posedge clk) disable iff (!rst_n)
        pop |=> (st_reg.sr[0] == $past(pop_bit)))
        else $error("serial bit not captured in first stage");

    AST_SHIFT_ON: assert property ( // [R3]
        @(posedge clk) disable iff (!rst_n)
        pop |=> (st_reg.sr[STAGES-1:1] == $past(st_reg.sr[STAGES-2:0])))
        else $error("stages did not move onward");

    AST_SR_STILL: assert property ( // [R9]
        @(posedge clk) disable iff (!rst_n)
        (!pop && st_reg.sync2.blank) |=> $stable(st_reg.sr))
        else $error("shift register changed without a shift");

    AST_LATCH_COPY: assert property ( // [R5]
        @(posedge clk) disable iff (!rst_n)
        latch_open |=> (st_reg.latch == $past(st_reg.sr)))
        else $error("latch did not copy stages");

    AST_LATCH_HOLD: assert property ( // [R6]
        @(posedge clk) disable iff (!rst_n)
        !st_reg.sync2.load |=> $stable(st_reg.latch))
        else $error("latch changed with load low");

    AST_CASCADE_EIGHT: assert property ( // [R12]
        @(posedge clk) disable iff (!rst_n)
        (pop && !shift_hold) ##1 (pop [*7]) |=> (ser_out == $past(pop_bit, 8)))
        else $error("bit not at cascade output after eight shifts");

    AST_EDGE_QUEUED: assert property ( // [R2]
        @(posedge clk) disable iff (!rst_n)
        (clk_rise && push_ready) |=> !$stable(u_fifo.st_reg.count) || $past(pop))
        else $error("shift clock rise not queued");

    // a lost rise must never pass silently; the flag is the only trace of it
    AST_OVERRUN_SET: assert property ( // [R2]
        @(posedge clk) disable iff (!rst_n)
        (push_valid && !push_ready) |=> overrun)
        else $error("lost shift clock rise not flagged");

    AST_OVERRUN_STICKY: assert property ( // [R2]
        @(posedge clk) disable iff (!rst_n)
        overrun |=> overrun)
        else $error("overrun flag cleared without reset");

    AST_LATCH_ONLY_COPY: assert property ( // [R1]
        @(posedge clk) disable iff (!rst_n)
        !latch_open |=> $stable(st_reg.latch))
        else $error("latch changed outside a copy");

endmodule
